// file: hw/bcp_bridge_control.sv
// Bridge control register and the policy logic it steers
`timescale 1ns/10ps
// How it works
// - A discard timer starts when a delayed completion reaches the queue head and drops it on expiry.
// - Bit 9 picks the discard interval: clear gives 2^15..2^16 clocks, set gives 2^10..2^11 clocks.
// - Bit 8 is stored and read back but steers nothing.
// - Fast back-to-back is never issued and bit 7 always reads zero.
// - Bit 6 set holds the secondary bus reset asserted; clear releases it.
// - A hub-side master abort with bit 5 set ends the PCI transaction with target abort.
// - A hub-side master abort with bit 5 clear completes with TRDY, reads return all ones, writes dropped.
// - A PCI master abort of a hub request sends a target-abort packet if bit 5 is set, else a normal completion.
// - With bit 3 set the legacy video memory and I/O ranges are decoded and forwarded downstream.
// - With bit 3 clear those ranges go downstream only inside the windows, and PCI accesses to them go upstream.
// - Bit 2 is stored and read back but changes no decoding.
// - A detected system error sends an upstream special cycle only when bit 1 is set.
// - With bit 0 set a data parity error drives the parity error pin and sets the detected flag.
// - With bit 0 clear a parity error neither drives the pin nor sets the flag.
// - Timer expiry sets write-one-to-clear bit 10 and with bits 11 and 1 set sends a system error cycle.

module bcp_bridge_control
    import bcp_pkg::*;
#(
    parameter int TMR_W = BCP_TMR_W
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Configuration access to the bridge control register
    input wire logic cfg_wr_i,
    input wire logic [1:0] cfg_be_i,
    input wire logic [15:0] cfg_wdata_i,
    output logic [15:0] cfg_rdata_o,
    // Bus frequency strap for bit 15
    input wire logic bus_66mhz_i,
    // Delayed transaction queue
    input wire logic dt_head_valid_i,
    input wire logic dt_repeat_done_i,
    output logic dt_discard_o,
    // Master aborts
    input wire logic hub_mabort_i,
    input wire logic hub_mabort_is_read_i,
    input wire logic pci_mabort_i,
    output logic pci_target_abort_o,
    output logic pci_trdy_complete_o,
    output logic pci_drop_wdata_o,
    output logic [31:0] pci_rdata_o,
    output bcp_pkg::bcp_upstream_s up_o,
    // Legacy video decode
    input wire bcp_pkg::bcp_dec_req_s hub_req_i,
    input wire logic hub_in_window_i,
    input wire bcp_pkg::bcp_dec_req_s pci_req_i,
    input wire logic pci_in_window_i,
    output logic fwd_down_o,
    output logic fwd_up_o,
    // Errors and bus pins
    input wire logic serr_seen_i,
    input wire logic parity_err_i,
    input wire logic sec_status_clr_i,
    output logic sec_parity_flag_o,
    output logic perr_n_o,
    output logic perr_oe_o,
    output logic pci_rst_n_o,
    output logic fast_b2b_o
);

    import bcp_pkg::*;

    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic sec_par_reg;
    logic sec_par_next;
    logic perr_reg;
    logic perr_next;
    bcp_upstream_s up_reg;
    bcp_upstream_s up_next;
    logic ta_reg;
    logic ta_next;
    logic trdy_reg;
    logic trdy_next;
    logic drop_reg;
    logic drop_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic expire;
    logic [15:0] wmask;
    logic hub_vga;
    logic pci_vga;

    // ----------------------------------------
    // Discard timer
    // ----------------------------------------
    bcp_discard_timer #(
        .TMR_W(TMR_W)
    ) u_timer (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .short_sel_i(ctrl_reg[BCP_TO_SEL_BIT]),
        .head_valid_i(dt_head_valid_i),
        .repeat_done_i(dt_repeat_done_i),
        .expire_o(expire),
        .counting_o()
    );

    // ----------------------------------------
    // Legacy video range match
    // ----------------------------------------
    function automatic logic vga_hit(input bcp_dec_req_s r);
        logic hit;
        hit = 1'b0;
        if (r.valid)
        begin
            if (r.is_io)
            begin
                hit = (r.addr >= BCP_VGA_IO1_LO && r.addr <= BCP_VGA_IO1_HI)
                    || (r.addr >= BCP_VGA_IO2_LO && r.addr <= BCP_VGA_IO2_HI);
            end
            else
            begin
                hit = (r.addr >= BCP_VGA_MEM_LO && r.addr <= BCP_VGA_MEM_HI);
            end
        end
        return hit;
    endfunction

    assign hub_vga = vga_hit(hub_req_i);
    assign pci_vga = vga_hit(pci_req_i);

    always_comb
    begin
        fwd_down_o = 1'b0;
        fwd_up_o = 1'b0;
        if (hub_req_i.valid)
        begin
            if (hub_vga && ctrl_reg[BCP_VGA_EN_BIT])
            begin
                fwd_down_o = 1'b1;
            end
            else
            begin
                fwd_down_o = hub_in_window_i;
            end
        end
        if (pci_req_i.valid)
        begin
            if (pci_vga)
            begin
                fwd_up_o = !ctrl_reg[BCP_VGA_EN_BIT];
            end
            else
            begin
                fwd_up_o = !pci_in_window_i;
            end
        end
    end

    // ----------------------------------------
    // Register and policy next values
    // ----------------------------------------
    always_comb
    begin
        wmask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
        ctrl_next = ctrl_reg;
        if (cfg_wr_i)
        begin
            // Bits 8 and 2 are kept only for software to read back
            ctrl_next = (ctrl_reg & ~(wmask & BCP_CTRL_RW_MASK)) | (cfg_wdata_i & wmask & BCP_CTRL_RW_MASK);
            if (cfg_be_i[1] && cfg_wdata_i[BCP_TO_STAT_BIT])
            begin
                ctrl_next[BCP_TO_STAT_BIT] = 1'b0;
            end
        end
        if (expire)
        begin
            ctrl_next[BCP_TO_STAT_BIT] = 1'b1;
        end
        ctrl_next[BCP_FB2B_BIT] = 1'b0;

        sec_par_next = sec_par_reg;
        if (sec_status_clr_i)
        begin
            sec_par_next = 1'b0;
        end
        if (parity_err_i && ctrl_reg[BCP_PERR_EN_BIT])
        begin
            sec_par_next = 1'b1;
        end
        perr_next = parity_err_i && ctrl_reg[BCP_PERR_EN_BIT];

        up_next.serr_cycle = (serr_seen_i && ctrl_reg[BCP_SERR_EN_BIT])
            || (expire && ctrl_reg[BCP_TO_SERR_EN_BIT] && ctrl_reg[BCP_SERR_EN_BIT]);
        up_next.abort_pkt = pci_mabort_i && ctrl_reg[BCP_ABORT_MODE_BIT];
        up_next.normal_pkt = pci_mabort_i && !ctrl_reg[BCP_ABORT_MODE_BIT];

        ta_next = hub_mabort_i && ctrl_reg[BCP_ABORT_MODE_BIT];
        trdy_next = hub_mabort_i && !ctrl_reg[BCP_ABORT_MODE_BIT];
        drop_next = trdy_next && !hub_mabort_is_read_i;
        rdata_next = (trdy_next && hub_mabort_is_read_i) ? BCP_ALL_ONES : rdata_reg;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_reg <= BCP_CTRL_RESET;
            sec_par_reg <= 1'b0;
            perr_reg <= 1'b0;
            up_reg <= '0;
            ta_reg <= 1'b0;
            trdy_reg <= 1'b0;
            drop_reg <= 1'b0;
            rdata_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            sec_par_reg <= sec_par_next;
            perr_reg <= perr_next;
            up_reg <= up_next;
            ta_reg <= ta_next;
            trdy_reg <= trdy_next;
            drop_reg <= drop_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb
    begin
        cfg_rdata_o = ctrl_reg;
        cfg_rdata_o[BCP_FB2B_BIT] = 1'b0;
        cfg_rdata_o[15] = bus_66mhz_i;
    end

    assign dt_discard_o = expire;
    assign pci_target_abort_o = ta_reg;
    assign pci_trdy_complete_o = trdy_reg;
    assign pci_drop_wdata_o = drop_reg;
    assign pci_rdata_o = rdata_reg;
    assign up_o = up_reg;
    assign sec_parity_flag_o = sec_par_reg;
    assign perr_n_o = !perr_reg;
    assign perr_oe_o = perr_reg;
    assign pci_rst_n_o = !ctrl_reg[BCP_SEC_RST_BIT];
    assign fast_b2b_o = 1'b0;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_hub_abort;
        hub_mabort_i;
    endsequence

    a_ta_on_abort: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s_hub_abort ##0 ctrl_reg[BCP_ABORT_MODE_BIT] |=> pci_target_abort_o && !pci_trdy_complete_o)
        else $error("target abort missing");
    a_trdy_ones: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s_hub_abort ##0 (!ctrl_reg[BCP_ABORT_MODE_BIT] && hub_mabort_is_read_i)
        |=> pci_trdy_complete_o && pci_rdata_o == BCP_ALL_ONES)
        else $error("all-ones completion missing");
    a_drop_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s_hub_abort ##0 (!ctrl_reg[BCP_ABORT_MODE_BIT] && !hub_mabort_is_read_i)
        |=> pci_trdy_complete_o && pci_drop_wdata_o)
        else $error("write data not dropped");
    a_serr_fwd: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        serr_seen_i && ctrl_reg[BCP_SERR_EN_BIT] |=> up_o.serr_cycle)
        else $error("system error cycle missing");
    a_vga_up: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        pci_req_i.valid && pci_vga && !ctrl_reg[BCP_VGA_EN_BIT] |-> fwd_up_o)
        else $error("legacy video access not sent upstream");
    a_stat_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        cfg_wr_i && cfg_be_i[1] && cfg_wdata_i[BCP_TO_STAT_BIT] && !expire |=> !ctrl_reg[BCP_TO_STAT_BIT])
        else $error("timeout status not cleared");
    a_up_packet: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        pci_mabort_i |=> (up_o.abort_pkt == $past(ctrl_reg[BCP_ABORT_MODE_BIT])) && (up_o.normal_pkt != up_o.abort_pkt))
        else $error("wrong upstream abort packet");
    a_sec_reset: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        pci_rst_n_o == !ctrl_reg[BCP_SEC_RST_BIT])
        else $error("secondary reset wrong");
    a_fb2b_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !cfg_rdata_o[BCP_FB2B_BIT] && !fast_b2b_o)
        else $error("fast back-to-back not zero");
    a_serr_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        serr_seen_i && !expire && !ctrl_reg[BCP_SERR_EN_BIT] |=> !up_o.serr_cycle)
        else $error("system error cycle while disabled");
    a_perr_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        parity_err_i && !ctrl_reg[BCP_PERR_EN_BIT] |=> !perr_oe_o)
        else $error("parity pin driven while disabled");
    a_perr_flag: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        parity_err_i && ctrl_reg[BCP_PERR_EN_BIT] |=> perr_oe_o && !perr_n_o && sec_parity_flag_o)
        else $error("parity response missing");
    a_expire_stat: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        expire |=> ctrl_reg[BCP_TO_STAT_BIT])
        else $error("timeout status not set");
    a_vga_fwd: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        hub_req_i.valid && hub_vga && ctrl_reg[BCP_VGA_EN_BIT] |-> fwd_down_o)
        else $error("legacy video not forwarded");

endmodule

// file: hw/bcp_pkg.sv
// Package: bridge control register layout, timing and carrier types
package bcp_pkg;

    // ----------------------------------------
    // Register layout
    // ----------------------------------------
    localparam logic [7:0] BCP_CTRL_OFFSET = 8'h3E;
    localparam logic [15:0] BCP_CTRL_RESET = 16'h0000;
    localparam int BCP_PERR_EN_BIT = 0;
    localparam int BCP_SERR_EN_BIT = 1;
    localparam int BCP_ISA_EN_BIT = 2;
    localparam int BCP_VGA_EN_BIT = 3;
    localparam int BCP_ABORT_MODE_BIT = 5;
    localparam int BCP_SEC_RST_BIT = 6;
    localparam int BCP_FB2B_BIT = 7;
    localparam int BCP_HUB_TO_BIT = 8;
    localparam int BCP_TO_SEL_BIT = 9;
    localparam int BCP_TO_STAT_BIT = 10;
    localparam int BCP_TO_SERR_EN_BIT = 11;
    // Bits software may write and read back as stored (0..3, 5, 6, 8, 9, 11)
    localparam logic [15:0] BCP_CTRL_RW_MASK = 16'h0B6F;

    // ----------------------------------------
    // Discard timer: counts are powers of two; the lower bound is used
    // ----------------------------------------
    localparam int BCP_LONG_TO_LOG2 = 15;
    localparam int BCP_SHORT_TO_LOG2 = 10;
    localparam int BCP_TMR_W = 16;

    // ----------------------------------------
    // Legacy video ranges
    // ----------------------------------------
    localparam logic [31:0] BCP_VGA_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] BCP_VGA_MEM_HI = 32'h000B_FFFF;
    localparam logic [31:0] BCP_VGA_IO1_LO = 32'h0000_03B0;
    localparam logic [31:0] BCP_VGA_IO1_HI = 32'h0000_03BB;
    localparam logic [31:0] BCP_VGA_IO2_LO = 32'h0000_03C0;
    localparam logic [31:0] BCP_VGA_IO2_HI = 32'h0000_03DF;
    localparam logic [31:0] BCP_ALL_ONES = 32'hFFFF_FFFF;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed
    {
        logic valid;
        logic is_io;
        logic [31:0] addr;
    } bcp_dec_req_s;

    typedef struct packed
    {
        logic abort_pkt;
        logic normal_pkt;
        logic serr_cycle;
    } bcp_upstream_s;

    typedef enum logic [1:0]
    {
        BCP_DT_IDLE = 2'b00,
        BCP_DT_COUNT = 2'b01,
        BCP_DT_EXPIRED = 2'b10
    } bcp_dt_state_e;

endpackage

// file: hw/bcp_discard_timer.sv
// Discard timer for the delayed completion at the head of the queue
`timescale 1ns/10ps

module bcp_discard_timer
    import bcp_pkg::*;
#(
    parameter int TMR_W = BCP_TMR_W
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Control
    input wire logic short_sel_i,
    input wire logic head_valid_i,
    input wire logic repeat_done_i,
    // Result
    output logic expire_o,
    output logic counting_o
);

    bcp_dt_state_e state_reg;
    bcp_dt_state_e state_next;
    logic [TMR_W-1:0] cnt_reg;
    logic [TMR_W-1:0] cnt_next;
    logic [TMR_W-1:0] limit;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        limit = short_sel_i ? TMR_W'(1 << BCP_SHORT_TO_LOG2) : TMR_W'(1 << BCP_LONG_TO_LOG2);
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            BCP_DT_IDLE:
            begin
                cnt_next = '0;
                if (head_valid_i && !repeat_done_i)
                begin
                    state_next = BCP_DT_COUNT;
                end
            end
            BCP_DT_COUNT:
            begin
                if (repeat_done_i || !head_valid_i)
                begin
                    state_next = BCP_DT_IDLE;
                    cnt_next = '0;
                end
                else if (cnt_reg >= limit - TMR_W'(1))
                begin
                    state_next = BCP_DT_EXPIRED;
                end
                else
                begin
                    cnt_next = cnt_reg + TMR_W'(1);
                end
            end
            default:
            begin
                state_next = BCP_DT_IDLE;
                cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            state_reg <= BCP_DT_IDLE;
            cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    assign expire_o = (state_reg == BCP_DT_EXPIRED);
    assign counting_o = (state_reg == BCP_DT_COUNT);

endmodule

// file: bench/bcp_queue_model.sv
// Delayed transaction queue head as seen from the hub side initiator
`timescale 1ns/10ps

module bcp_queue_model
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Bench control: load a completion, repeat after n cycles (0 = never)
    input wire logic load_i,
    input wire logic [15:0] repeat_after_i,
    // From the block
    input wire logic discard_i,
    // To the block
    output logic head_valid_o,
    output logic repeat_done_o
);
    logic [15:0] age_reg;

    always_ff @(posedge ref_clk_i)
    begin
        repeat_done_o <= 1'b0;
        if (!reset_n_i)
        begin
            head_valid_o <= 1'b0;
            age_reg <= 16'h0000;
        end
        else if (load_i)
        begin
            head_valid_o <= 1'b1;
            age_reg <= 16'h0000;
        end
        else if (head_valid_o)
        begin
            // A discarded completion leaves the queue and is not repeated
            if (discard_i)
                head_valid_o <= 1'b0;
            else if (repeat_after_i != 16'h0000 && age_reg == repeat_after_i)
            begin
                repeat_done_o <= 1'b1;
                head_valid_o <= 1'b0;
            end
            else
                age_reg <= age_reg + 16'h0001;
        end
    end
endmodule

// file: bench/bcp_bridge_control_tb.sv
// Self-checking bench for the bridge control and policy block
`timescale 1ns/10ps

module bcp_bridge_control_tb;
    import bcp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic cfg_wr_i = 1'b0;
    logic [1:0] cfg_be_i = 2'b00;
    logic [15:0] cfg_wdata_i = 16'h0000;
    logic [15:0] cfg_rdata_o;
    logic bus_66mhz_i = 1'b0;
    logic dt_head_valid_i, dt_repeat_done_i, dt_discard_o;
    logic hub_mabort_i = 1'b0;
    logic hub_mabort_is_read_i = 1'b0;
    logic pci_mabort_i = 1'b0;
    logic pci_target_abort_o, pci_trdy_complete_o, pci_drop_wdata_o;
    logic [31:0] pci_rdata_o;
    bcp_upstream_s up_o;
    bcp_dec_req_s hub_req_i = '0;
    bcp_dec_req_s pci_req_i = '0;
    logic hub_in_window_i = 1'b0;
    logic pci_in_window_i = 1'b0;
    logic fwd_down_o, fwd_up_o;
    logic serr_seen_i = 1'b0;
    logic parity_err_i = 1'b0;
    logic sec_status_clr_i = 1'b0;
    logic sec_parity_flag_o, perr_n_o, perr_oe_o, pci_rst_n_o, fast_b2b_o;
    logic q_load = 1'b0;
    logic [15:0] q_rep_after = 16'h0000;
    int failures = 0;
    int n_compared = 0;
    // Legacy video probe table: boundaries and first address outside
    localparam logic [31:0] VA [10] = '{32'h000A_0000, 32'h000B_FFFF, 32'h0009_FFFF, 32'h000C_0000,
        32'h0000_03B0, 32'h0000_03BB, 32'h0000_03BC, 32'h0000_03C0, 32'h0000_03DF, 32'h0000_03E0};
    localparam logic [9:0] VIO = 10'b11_1111_0000;
    localparam logic [9:0] VIN = 10'b01_1011_0011;

    always #2.5 ref_clk_i = ~ref_clk_i;

    bcp_bridge_control u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cfg_wr_i(cfg_wr_i),
        .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .bus_66mhz_i(bus_66mhz_i),
        .dt_head_valid_i(dt_head_valid_i), .dt_repeat_done_i(dt_repeat_done_i), .dt_discard_o(dt_discard_o),
        .hub_mabort_i(hub_mabort_i), .hub_mabort_is_read_i(hub_mabort_is_read_i), .pci_mabort_i(pci_mabort_i),
        .pci_target_abort_o(pci_target_abort_o), .pci_trdy_complete_o(pci_trdy_complete_o),
        .pci_drop_wdata_o(pci_drop_wdata_o), .pci_rdata_o(pci_rdata_o), .up_o(up_o), .hub_req_i(hub_req_i),
        .hub_in_window_i(hub_in_window_i), .pci_req_i(pci_req_i), .pci_in_window_i(pci_in_window_i),
        .fwd_down_o(fwd_down_o), .fwd_up_o(fwd_up_o), .serr_seen_i(serr_seen_i), .parity_err_i(parity_err_i),
        .sec_status_clr_i(sec_status_clr_i), .sec_parity_flag_o(sec_parity_flag_o), .perr_n_o(perr_n_o),
        .perr_oe_o(perr_oe_o), .pci_rst_n_o(pci_rst_n_o), .fast_b2b_o(fast_b2b_o));

    bcp_queue_model u_queue (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .load_i(q_load),
        .repeat_after_i(q_rep_after), .discard_i(dt_discard_o), .head_valid_o(dt_head_valid_i),
        .repeat_done_o(dt_repeat_done_i));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] d, input logic [1:0] be);
        @(negedge ref_clk_i);
        cfg_wr_i = 1'b1;
        cfg_be_i = be;
        cfg_wdata_i = d;
        @(negedge ref_clk_i);
        cfg_wr_i = 1'b0;
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reg();
        chk(cfg_rdata_o, 32'h0000_0000, "reset value");
        chk({pci_rst_n_o, perr_n_o, perr_oe_o, fast_b2b_o}, 32'h0000_000C, "reset pins");
        wr(16'hFFFF, 2'b11);
        chk(cfg_rdata_o, 32'h0000_0B6F, "all ones write");
        chk(pci_rst_n_o, 1'b0, "secondary reset on");
        bus_66mhz_i = 1'b1;
        #1;
        chk(cfg_rdata_o, 32'h0000_8B6F, "frequency bit");
        wr(16'h0000, 2'b01);
        chk(cfg_rdata_o, 32'h0000_8B00, "low lane only");
        chk(pci_rst_n_o, 1'b1, "secondary reset off");
        wr(16'h0000, 2'b10);
        bus_66mhz_i = 1'b0;
        #1;
        chk(cfg_rdata_o, 32'h0000_0000, "cleared");
        chk(fast_b2b_o, 1'b0, "no fast back to back");
    endtask

    task automatic t_abort();
        for (int m = 0; m < 2; m++)
            for (int r = 0; r < 2; r++)
            begin
                wr(m ? 16'h0020 : 16'h0000, 2'b11);
                @(negedge ref_clk_i);
                hub_mabort_i = 1'b1;
                hub_mabort_is_read_i = r[0];
                pci_mabort_i = 1'b1;
                @(negedge ref_clk_i);
                hub_mabort_i = 1'b0;
                pci_mabort_i = 1'b0;
                chk(pci_target_abort_o, m, "target abort");
                chk(pci_trdy_complete_o, !m, "trdy complete");
                chk(pci_drop_wdata_o, !m && !r, "drop write data");
                if (!m && r)
                    chk(pci_rdata_o, 32'hFFFF_FFFF, "all ones read");
                chk({up_o.abort_pkt, up_o.normal_pkt}, m ? 2 : 1, "upstream packet");
                @(negedge ref_clk_i);
                chk({pci_target_abort_o, pci_trdy_complete_o, up_o}, 0, "one cycle pulses");
            end
    endtask

    task automatic t_vga();
        for (int v = 0; v < 2; v++)
        begin
            wr(v ? 16'h0008 : 16'h0004, 2'b01);
            for (int w = 0; w < 2; w++)
                for (int i = 0; i < 10; i++)
                begin
                    @(negedge ref_clk_i);
                    hub_req_i = '{1'b1, VIO[i], VA[i]};
                    pci_req_i = '{1'b1, VIO[i], VA[i]};
                    hub_in_window_i = w[0];
                    pci_in_window_i = w[0];
                    #1;
                    chk(fwd_down_o, w[0] | (v[0] & VIN[i]), "downstream decode");
                    chk(fwd_up_o, VIN[i] ? !v[0] : !w[0], "upstream decode");
                end
        end
        hub_req_i = '0;
        pci_req_i = '0;
    endtask

    task automatic t_errs();
        for (int e = 0; e < 2; e++)
        begin
            wr(e ? 16'h0003 : 16'h0000, 2'b01);
            @(negedge ref_clk_i);
            serr_seen_i = 1'b1;
            parity_err_i = 1'b1;
            @(negedge ref_clk_i);
            serr_seen_i = 1'b0;
            parity_err_i = 1'b0;
            chk(up_o.serr_cycle, e, "serr special cycle");
            chk({perr_n_o, perr_oe_o}, e ? 1 : 2, "parity pin");
            chk(sec_parity_flag_o, e, "parity flag");
            @(negedge ref_clk_i);
            sec_status_clr_i = 1'b1;
            @(negedge ref_clk_i);
            sec_status_clr_i = 1'b0;
            chk(sec_parity_flag_o, 1'b0, "parity flag clear");
            if (e)
            begin
                @(negedge ref_clk_i);
                parity_err_i = 1'b1;
                sec_status_clr_i = 1'b1;
                @(negedge ref_clk_i);
                parity_err_i = 1'b0;
                sec_status_clr_i = 1'b0;
                chk(sec_parity_flag_o, 1'b1, "parity set beats clear");
            end
        end
    endtask

    task automatic t_timer(input logic [15:0] ctrl, input int lo, input int hi, input int rep);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        wr(ctrl, 2'b11);
        @(negedge ref_clk_i);
        q_rep_after = rep[15:0];
        q_load = 1'b1;
        @(negedge ref_clk_i);
        q_load = 1'b0;
        while (dt_discard_o !== 1'b1 && n < hi + 8)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        if (rep > 0)
            chk(n, hi + 8, "no discard after repeat");
        else
        begin
            chk(n >= lo && n <= hi, 1, "discard interval");
            @(negedge ref_clk_i);
            chk({dt_discard_o, cfg_rdata_o[10]}, 1, "status after expiry");
            repeat (3)
            begin
                seen = seen | up_o.serr_cycle;
                @(negedge ref_clk_i);
            end
            chk(seen, ctrl[11] & ctrl[1], "timeout serr");
            wr(16'h0400, 2'b10);
            chk(cfg_rdata_o[10], 1'b0, "status write one clear");
        end
    endtask

    initial
    begin
        repeat (12) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        t_reg();
        t_abort();
        t_vga();
        t_errs();
        t_timer(16'h0A02, 1024, 2052, 0);
        t_timer(16'h0200, 1024, 2052, 500);
        t_timer(16'h0002, 32768, 65540, 0);
        give_verdict();
    end

    initial
    begin
        #500000;
        failures++;
        give_verdict();
    end
endmodule
